/* File: include/fusa_cfg.svh */
/*
  fusa_cfg.svh: named offsets, field positions, reset values and
  pulse lengths for the flash microsecond tick and address block.
  assumes it is included by bare name wherever a figure is needed.
*/
`ifndef FUSA_CFG_SVH
`define FUSA_CFG_SVH

// register offsets on the plain register port (byte addresses)
`define FUSA_ADDR_OFS      12'h000
`define FUSA_CTRL_OFS      12'h008
`define FUSA_RELOAD_OFS    12'h140

// field widths and positions
`define FUSA_BUS_AW        12
`define FUSA_DW            32
`define FUSA_ADDR_W        16
`define FUSA_RELOAD_W      8
`define FUSA_CTL_WRITE_BIT 0
`define FUSA_CTL_ERASE_BIT 1
`define FUSA_WORD_LSB      2
`define FUSA_PAGE_LSB      10

// reset values
`define FUSA_RELOAD_RST    8'h31
`define FUSA_ADDR_RST      16'h0000
`define FUSA_DATA_RST      32'h0000_0000

// tick spacing at the reset reload value, in clk_sys cycles
`define FUSA_RST_PERIOD    9'h032

// control write patterns that start an operation
`define FUSA_CTL_PROG      2'h1
`define FUSA_CTL_ERASE     2'h2

// high-voltage pulse count width, and pulse lengths in microsecond ticks
`define FUSA_PULSE_W       16
`define FUSA_PROG_PULSE_US 16'd40
`define FUSA_ERASE_PULSE_US 16'd2000

`endif

/* File: include/fusa_pkg.sv */
/*
  fusa_pkg: types shared by the flash tick and address block.
  assumes fusa_cfg.svh is on the include path.
*/
`include "fusa_cfg.svh"

package fusa_pkg;

  // sequencer states
  typedef enum logic {
    FUSA_IDLE,
    FUSA_PULSE
  } fusa_state_e;

  // kind of high-voltage operation
  typedef enum logic {
    FUSA_OP_PROG,
    FUSA_OP_ERASE
  } fusa_op_e;

  typedef logic [`FUSA_RELOAD_W-1:0] fusa_reload_t;
  typedef logic [`FUSA_ADDR_W-1:0]   fusa_addr_t;
  typedef logic [`FUSA_PULSE_W-1:0]  fusa_pulse_t;

endpackage

/* File: include/fusa_tick_if.sv */
/*
  fusa_tick_if: reload value, restart strobe and tick between the
  register/sequencer logic and the microsecond divider.
  assumes both ends run on clk_sys.
*/
`timescale 1ns/1ns

interface fusa_tick_if import fusa_pkg::*; ();
  fusa_reload_t reload;   // divide-by value minus one
  logic         restart;  // reload the divider now
  logic         tick;     // one-cycle microsecond tick

  modport ctl (output reload, output restart, input tick);
  modport div (input reload, input restart, output tick);
endinterface

/* File: rtl/fusa_tick_div.sv */
/*
  fusa_tick_div: down counter that divides clk_sys into a one
  microsecond tick, reloading from the software reload value.
  assumes reload is stable register output on the same clock.
*/
`timescale 1ns/1ns

module fusa_tick_div import fusa_pkg::*; (
  input wire logic clk_sys,
  input wire logic arst_n,
  fusa_tick_if.div tk
);

  fusa_reload_t cnt_r;    // cycles left in this period
  fusa_reload_t cnt_nxt;  // next count
  logic         tick_r;   // registered tick
  wire          at_zero;  // period ends this cycle

  // end of period when the count has run down
  assign at_zero = (cnt_r == '0);

  // reload on restart or period end, else count down
  assign cnt_nxt = (tk.restart || at_zero) ? tk.reload
                                           : cnt_r - 8'h01;

  assign tk.tick = tick_r;

  // counter and tick flop; reload plus one cycles a period
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r  <= `FUSA_RELOAD_RST;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= at_zero && !tk.restart;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  chk_tick_reload: assert property (
    at_zero && !tk.restart |=> cnt_r == $past(tk.reload) && tick_r)
    else $error("divider did not reload at period end");

  chk_tick_single: assert property (
    tick_r && cnt_r != '0 && !tk.restart |=> !tick_r)
    else $error("tick lasted more than one cycle");

endmodule

/* File: rtl/fusa_top.sv */
/*
  fusa_top: flash target address, microsecond tick reload and the
  operation start/pulse timing of the flash controller.
  assumes a one-clock register master with single-cycle strobes,
  and the flash data word supplied by logic outside this block.
  pulse lengths are parameters so a bench may shorten them.
*/
// Functional notes
// - divider makes one microsecond tick from reload
// - tick times the high-voltage pulse length
// - reload field resets to 0x31, 50 MHz
// - program writes data at word-aligned target (low address bits are passed as is)
// - page erase uses one-kilobyte aligned target (low address bits are passed as is)
// - control write starts access at target address
`timescale 1ns/1ns

module fusa_top import fusa_pkg::*; #(
  parameter fusa_pulse_t PROG_PULSE_US  = `FUSA_PROG_PULSE_US,
  parameter fusa_pulse_t ERASE_PULSE_US = `FUSA_ERASE_PULSE_US
) (
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  input  wire logic [`FUSA_BUS_AW-1:0] bus_addr,
  input  wire logic [`FUSA_DW-1:0]    bus_wdata,
  input  wire logic                   bus_wr,
  input  wire logic                   bus_rd,
  output      logic [`FUSA_DW-1:0]    bus_rdata,
  input  wire logic [`FUSA_DW-1:0]    prog_data,
  output      logic [`FUSA_ADDR_W-1:0] fl_addr,
  output      logic [`FUSA_DW-1:0]    fl_wdata,
  output      logic                   fl_prog,
  output      logic                   fl_erase,
  output      logic                   op_busy,
  output      logic                   op_done,
  output      logic                   us_tick
);

  // tick link to the divider
  fusa_tick_if tk ();

  // software registers
  fusa_addr_t   addr_r;      // flash target address
  fusa_reload_t reload_r;    // microsecond tick reload
  logic [`FUSA_DW-1:0] rdata_r; // read data, one cycle late

  // sequencer state
  fusa_state_e  state_r;     // idle or pulsing
  fusa_state_e  state_nxt;   // next state
  fusa_op_e     op_r;        // kind of operation running
  fusa_pulse_t  pcnt_r;      // ticks left in the pulse
  fusa_pulse_t  pcnt_nxt;    // next tick count
  fusa_addr_t   fl_addr_r;   // address latched at start
  logic [`FUSA_DW-1:0] fl_wdata_r; // data latched at start
  logic         done_r;      // end-of-operation pulse

  // address decode
  wire sel_addr   = (bus_addr == `FUSA_ADDR_OFS);
  wire sel_ctrl   = (bus_addr == `FUSA_CTRL_OFS);
  wire sel_reload = (bus_addr == `FUSA_RELOAD_OFS);

  // write strobes per register
  wire wr_addr   = bus_wr && sel_addr;
  wire wr_ctrl   = bus_wr && sel_ctrl;
  wire wr_reload = bus_wr && sel_reload;

  // control write decode: exactly one operation bit
  wire [1:0] ctl_bits = {bus_wdata[`FUSA_CTL_ERASE_BIT],
                         bus_wdata[`FUSA_CTL_WRITE_BIT]};
  wire req_prog  = wr_ctrl && (ctl_bits == `FUSA_CTL_PROG);
  wire req_erase = wr_ctrl && (ctl_bits == `FUSA_CTL_ERASE);

  // sequencer status
  wire idle     = (state_r == FUSA_IDLE);
  wire in_pulse = (state_r == FUSA_PULSE);

  // start only from idle; writes while busy are dropped
  wire start    = idle && (req_prog || req_erase);

  // pulse ends on the last counted tick
  wire last_tk  = in_pulse && tk.tick && (pcnt_r == 16'd1);

  // length chosen by kind of operation
  wire fusa_pulse_t start_len = req_erase ? ERASE_PULSE_US
                                          : PROG_PULSE_US;

  // next state
  assign state_nxt = start   ? FUSA_PULSE :
                     last_tk ? FUSA_IDLE  : state_r;

  // tick counter: load at start, count down on ticks
  assign pcnt_nxt = start ? start_len :
                    (in_pulse && tk.tick) ? pcnt_r - 16'd1 : pcnt_r;

  // divider restarts with the pulse so the first tick is whole
  assign tk.restart = start;
  assign tk.reload  = reload_r;

  // read mux; reserved bits stay zero
  wire [`FUSA_DW-1:0] rd_addr_w   = {16'h0000, addr_r};
  wire [`FUSA_DW-1:0] rd_reload_w = {24'h00_0000, reload_r};
  wire [`FUSA_DW-1:0] rd_ctrl_w   = {30'h0000_0000,
                                     in_pulse && op_r == FUSA_OP_ERASE,
                                     in_pulse && op_r == FUSA_OP_PROG};
  wire [`FUSA_DW-1:0] rd_mux_w    =
    sel_addr   ? rd_addr_w   :
    sel_reload ? rd_reload_w :
    sel_ctrl   ? rd_ctrl_w   : 32'h0000_0000;

  // microsecond divider
  fusa_tick_div u_div (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .tk      (tk.div)
  );

  // target address register, low sixteen bits only
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      addr_r <= `FUSA_ADDR_RST;
    end else if (wr_addr) begin
      addr_r <= bus_wdata[`FUSA_ADDR_W-1:0];
    end
  end

  // reload register; takes effect at next period
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reload_r <= `FUSA_RELOAD_RST;
    end else if (wr_reload) begin
      reload_r <= bus_wdata[`FUSA_RELOAD_W-1:0];
    end
  end

  // read data flop, valid only the cycle after the strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= `FUSA_DATA_RST;
    end else if (bus_rd) begin
      rdata_r <= rd_mux_w;
    end else begin
      rdata_r <= `FUSA_DATA_RST;
    end
  end

  // sequencer state and tick count
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= FUSA_IDLE;
      pcnt_r  <= '0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pcnt_r  <= pcnt_nxt;
      done_r  <= last_tk;
    end
  end

  // latch kind, target and data as the operation starts
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      op_r       <= FUSA_OP_PROG;
      fl_addr_r  <= `FUSA_ADDR_RST;
      fl_wdata_r <= `FUSA_DATA_RST;
    end else if (start) begin
      // program targets the word, erase the page
      op_r       <= req_erase ? FUSA_OP_ERASE : FUSA_OP_PROG;
      fl_addr_r  <= addr_r;
      fl_wdata_r <= prog_data;
    end
  end

  // array side outputs; misaligned low bits are passed as is
  assign fl_addr   = fl_addr_r;
  assign fl_wdata  = fl_wdata_r;
  assign fl_prog   = in_pulse && (op_r == FUSA_OP_PROG);
  assign fl_erase  = in_pulse && (op_r == FUSA_OP_ERASE);
  assign op_busy   = in_pulse;
  assign op_done   = done_r;
  assign us_tick   = tk.tick;
  assign bus_rdata = rdata_r;

  // checking helpers: ticks seen and length of running pulse
  fusa_pulse_t seen_r;       // ticks counted during the pulse
  fusa_pulse_t len_r;        // pulse length latched at start

  // helper counters read only by the checks below
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      seen_r <= '0;
      len_r  <= '0;
    end else if (start) begin
      seen_r <= '0;
      len_r  <= start_len;
    end else if (in_pulse && tk.tick) begin
      seen_r <= seen_r + 16'd1;
    end
  end

  // tick spacing helpers, read only by chk_tick_gap below; the
  // period after a tick is armed when it runs at the reset reload
  wire tick_at_rst = (reload_r == `FUSA_RELOAD_RST) && !start
                     && !wr_reload;
  logic [`FUSA_RELOAD_W:0] gap_r;      // cycles since the last tick
  logic                    gap_arm_r;  // period under way is armed

  // cycles since the last tick, held once past any legal period
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gap_r <= '0;
    end else if (us_tick) begin
      gap_r <= 9'h001;
    end else if (gap_r != '1) begin
      gap_r <= gap_r + 9'h001;
    end
  end

  // arm at each tick run at the reset reload; a start restarts the divider, so disarm
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gap_arm_r <= 1'b0;
    end else if (us_tick) begin
      gap_arm_r <= tick_at_rst;
    end else if (start) begin
      gap_arm_r <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // a program start and an erase start, one cycle each
  sequence seq_start_prog;
    req_prog && idle;
  endsequence

  sequence seq_start_erase;
    req_erase && idle;
  endsequence

  chk_start_busy: assert property (
    (seq_start_prog or seq_start_erase) |=> op_busy)
    else $error("control write did not start operation");

  chk_busy_drop: assert property (
    op_busy && wr_ctrl && !last_tk |=> $stable(op_r) && op_busy)
    else $error("control write while busy disturbed operation");

  chk_pulse_len: assert property (
    op_done |-> seen_r == len_r && !op_busy)
    else $error("pulse length differs from tick count");

  chk_prog_addr: assert property (
    seq_start_prog |=> fl_prog && fl_addr == $past(addr_r)
                       && fl_wdata == $past(prog_data))
    else $error("program target or data not latched");

  chk_erase_page: assert property (
    seq_start_erase |=> fl_erase && fl_addr == $past(addr_r))
    else $error("erase target not latched");

  chk_hv_excl: assert property (
    !(fl_prog && fl_erase))
    else $error("program and erase pulses together");

  chk_tick_gap: assert property (
    gap_arm_r |-> gap_r <= `FUSA_RST_PERIOD
                  && us_tick == (gap_r == `FUSA_RST_PERIOD))
    else $error("tick period wrong at reset reload");

  chk_addr_rsv: assert property (
    bus_rd && sel_addr |=> bus_rdata[31:16] == 16'h0000
                           && bus_rdata[15:0] == $past(addr_r))
    else $error("address read back wrong");

  chk_reload_rsv: assert property (
    bus_rd && sel_reload |=> bus_rdata[31:8] == 24'h00_0000
                             && bus_rdata[7:0] == $past(reload_r))
    else $error("reload read back wrong");

  chk_rd_once: assert property (
    !bus_rd |=> bus_rdata == 32'h0000_0000)
    else $error("read data stood past one cycle");

  // the pulse ends on its last counted tick
  sequence seq_pulse_end;
    in_pulse && tk.tick && pcnt_r == 16'd1;
  endsequence

  chk_pulse_end: assert property (
    seq_pulse_end |=> !op_busy && op_done)
    else $error("pulse did not end after its last tick");

  chk_done_once: assert property (
    op_done |=> !op_done)
    else $error("done pulse lasted more than one cycle");

  chk_first_tick: assert property (
    start |=> !us_tick)
    else $error("tick came right after a pulse start");

endmodule

/* File: verif/fusa_flash_model.sv */
/*
  fusa_flash_model: flash array seen from the pulse lines; logs the
  target, data, kind and length in cycles of each pulse.
  assumes fl_* are registered design outputs on clk_sys.
*/
`timescale 1ns/1ns

module fusa_flash_model (
  input  wire logic        clk_sys,
  input  wire logic        fl_prog,
  input  wire logic        fl_erase,
  input  wire logic [15:0] fl_addr,
  input  wire logic [31:0] fl_wdata,
  output      logic [31:0] pulse_len,
  output      logic [15:0] op_addr,
  output      logic [31:0] op_data,
  output      logic        op_erase
);
  logic pulse_q = 1'b0;  // pulse seen at previous edge

  // capture each pulse at its rise, then count its cycles
  always @(posedge clk_sys) begin
    pulse_q <= fl_prog | fl_erase;
    if ((fl_prog | fl_erase) && !pulse_q) begin
      pulse_len <= 32'h1;
      op_addr   <= fl_addr;
      op_data   <= fl_wdata;
      op_erase  <= fl_erase;
    end else if (fl_prog | fl_erase) begin
      pulse_len <= pulse_len + 32'h1;
    end
  end
endmodule

/* File: verif/tb.sv */
/*
  tb: register-level regression of the flash tick and address block.
  assumes package, interface, design and flash model compiled first.
*/
`timescale 1ns/1ns
`include "fusa_cfg.svh"

module tb;
  logic        clk_sys, arst_n, bus_wr, bus_rd;  // clock, reset, strobes
  logic [11:0] bus_addr;                         // register address
  logic [31:0] bus_wdata, bus_rdata, prog_data;  // bus and data word
  logic [31:0] fl_wdata, m_len, m_data;          // flash side data
  logic [15:0] fl_addr, m_addr;                  // flash targets
  logic        fl_prog, fl_erase, op_busy, op_done, us_tick, m_erase;
  int          num_errors = 0;                   // mismatches seen
  int          checks_done = 0;                  // compares made
  int          n;                                // measured count

  fusa_top #(.PROG_PULSE_US(16'h0002), .ERASE_PULSE_US(16'h0003))
    fusa_top_i (.clk_sys(clk_sys), .arst_n(arst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .prog_data(prog_data), .fl_addr(fl_addr),
    .fl_wdata(fl_wdata), .fl_prog(fl_prog), .fl_erase(fl_erase),
    .op_busy(op_busy), .op_done(op_done), .us_tick(us_tick));

  fusa_flash_model fusa_flash_model_i (.clk_sys(clk_sys),
    .fl_prog(fl_prog), .fl_erase(fl_erase), .fl_addr(fl_addr),
    .fl_wdata(fl_wdata), .pulse_len(m_len), .op_addr(m_addr),
    .op_data(m_data), .op_erase(m_erase));

  // compare and count
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask

  // one-cycle read strobe, data checked in the following cycle
  task automatic rd(input string what, input logic [11:0] a,
                    input logic [31:0] exp);
    @(posedge clk_sys);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1 chk(what, exp, bus_rdata);
  endtask

  // cycles until the next tick is seen
  task automatic tick_gap(output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      #1 c++;
    end while (us_tick !== 1'b1 && c < 400);
  endtask

  // settle on the new reload, then measure one tick period
  task automatic period(input int exp);
    tick_gap(n);
    tick_gap(n);
    tick_gap(n);
    chk("tick period", exp, n);
  endtask

  // start an operation, try a second start, wait for the end
  task automatic op(input logic [31:0] cw, input logic [31:0] len,
                    input logic [15:0] a);
    wr(`FUSA_CTRL_OFS, cw);
    rd("busy bits", `FUSA_CTRL_OFS, cw);
    wr(`FUSA_CTRL_OFS, cw ^ 32'h3);
    rd("start while busy", `FUSA_CTRL_OFS, cw);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (op_done !== 1'b1 && n < 2000);
    chk("busy at done", 32'h0, op_busy);
    chk("pulse length", len, m_len);
    chk("target", a, m_addr);
    chk("kind", cw[1], m_erase);
    chk("data", prog_data, m_data);
    @(posedge clk_sys);
    #1 chk("done one cycle", 32'h0, op_done);
    $display("test op %h done", cw);
  endtask

  // verdict
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // clock, 100 ns period
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // watchdog, far beyond the expected few hundred cycles
  initial begin
    #3_000_000;
    num_errors++;
    finish_test();
  end

  // main sequence
  initial begin
    arst_n    = 1'b0;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    bus_addr  = 12'h000;
    bus_wdata = 32'h0;
    prog_data = 32'ha5a5_1234;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd("address reset", `FUSA_ADDR_OFS, 32'h0);
    rd("reload reset", `FUSA_RELOAD_OFS, 32'h31);
    rd("unmapped read", 12'h004, 32'h0);
    period(50);
    $display("test reset done");
    wr(`FUSA_RELOAD_OFS, 32'hffff_ff05);
    rd("reload field", `FUSA_RELOAD_OFS, 32'h05);
    wr(`FUSA_ADDR_OFS, 32'hffff_0404);
    rd("address field", `FUSA_ADDR_OFS, 32'h0404);
    period(6);
    $display("test registers done");
    op(32'h1, 32'd13, 16'h0404);
    wr(`FUSA_RELOAD_OFS, 32'h02);
    wr(`FUSA_ADDR_OFS, 32'h0800);
    prog_data <= 32'h5a5a_00ff;
    op(32'h2, 32'd10, 16'h0800);
    wr(`FUSA_CTRL_OFS, 32'h3);
    rd("multi-bit start", `FUSA_CTRL_OFS, 32'h0);
    chk("busy after multi-bit", 32'h0, op_busy);
    $display("test refusals done");
    finish_test();
  end
endmodule
